// [src/dac_consts.svh]
// Offsets, field positions, reset values and sizes of the quad DAC front end
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

// ----------------------------------------------------------------
// Serial word
// ----------------------------------------------------------------
`define WORD_BITS        16
`define WORD_LAST_BIT    4'hF
`define WORD_CH_HI       15
`define WORD_CH_LO       14
`define WORD_DATA_HI     11
`define WORD_DATA_LO     0

// ----------------------------------------------------------------
// Preset codes
// ----------------------------------------------------------------
`define CODE_ZERO        12'h000
`define CODE_MID         12'h800

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_W           8
`define OFF_CTRL         8'h00
`define OFF_STATUS       8'h04
`define OFF_FRAME        8'h08
`define BANK_INPUT       4'h1
`define BANK_DAC         4'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_SOFT_CLEAR  0
`define CTRL_SOFT_LOAD   1
`define STAT_PENDING     0
`define STAT_CLEARING    1
`define STAT_LEVEL       2
`define STAT_CNT_LO      8
`define STAT_CNT_HI      23

`endif

// [src/dac_pkg.sv]
// Types shared by the quad DAC front end
package dac_pkg;

    typedef logic [11:0] code_t;
    typedef logic [1:0]  chan_t;
    typedef logic [15:0] word_t;
    typedef logic [15:0] count_t;

endpackage

// [src/serial_shift.sv]
// Serial input register on the link clock, with frame hand-off
`timescale 1ns/1ps
`include "dac_consts.svh"

module serial_shift
    import dac_pkg::*;
(
    input  wire logic     serial_clk,
    input  wire logic     presetn,
    input  wire logic     sel_n,
    input  wire logic     serial_bit_in,
    output dac_pkg::word_t word_hold,
    output logic          word_toggle
);
    import dac_pkg::*;

    word_t      shift_reg;
    logic [3:0] bit_cnt_reg;
    logic       frame_rst_n;

    // Deselect ends the frame; the link clock may stop right after
    assign frame_rst_n = presetn & ~sel_n;

    // ----------------------------------------------------------------
    // Bit counter
    // ----------------------------------------------------------------
    always_ff @(posedge serial_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            bit_cnt_reg <= 4'h0;
        else
            bit_cnt_reg <= bit_cnt_reg + 4'h1;   // [R10]
    end

    // ----------------------------------------------------------------
    // Shift register
    // ----------------------------------------------------------------
    // Select gating kept as an enable, same effect as the OR-ed clock
    // without the spurious edge when select rises with the clock low
    always_ff @(posedge serial_clk or negedge presetn)
    begin
        if (!presetn)
            shift_reg <= 16'h0000;
        else if (!sel_n)                                  // [R3] [R5]
            shift_reg <= {shift_reg[14:0], serial_bit_in}; // [R2]
    end

    // ----------------------------------------------------------------
    // Completed word, stable for a whole following frame
    // ----------------------------------------------------------------
    always_ff @(posedge serial_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_hold   <= 16'h0000;
            word_toggle <= 1'b0;
        end
        else if (!sel_n && bit_cnt_reg == `WORD_LAST_BIT)  // [R10]
        begin
            word_hold   <= {shift_reg[14:0], serial_bit_in};
            word_toggle <= ~word_toggle;
        end
    end

endmodule

// [src/quad_dac_serial_load_clear.sv]
// Quad 12-bit DAC digital front end: serial link, load, clear, APB
//
// Notes on behaviour
// R1 - Controller presents each data bit valid at the rising link clock.
// R2 - One bit shifts in on every rising link clock while selected.
// R3 - Data line ignored entirely while select is high.
// R4 - Controller holds select low for every bit it sends.
// R5 - Select gates the shift clock; high select blocks all shifting. Here select is a shift enable; the clock is not gated.
// R6 - Load strobe falling edge copies the serial word into DAC codes.
// R7 - Controller keeps the word stable while load strobe is low.
// R8 - Clear presets input and DAC codes: midscale if level high, else zero.
// R9 - Clear never touches the serial input register.
// R10 - Each write is one 16-bit word framed by select.
// R11 - Clear needs no link clock and holds the preset while asserted.
// R12 - Word: bits 15:14 channel, 11:0 code, 13:12 ignored.
`timescale 1ns/1ps
`include "dac_consts.svh"

module quad_dac_serial_load_clear
    import dac_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_clk,
    input  wire logic        sel_n,
    input  wire logic        serial_bit_in,
    input  wire logic        load_strobe_n,
    input  wire logic        preset_strobe_n,
    input  wire logic        preset_level_choice,
    output dac_pkg::code_t   dac_code_0,
    output dac_pkg::code_t   dac_code_1,
    output dac_pkg::code_t   dac_code_2,
    output dac_pkg::code_t   dac_code_3,
    output logic             dac_update
);
    import dac_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    word_t       word_hold;
    logic        word_toggle;

    logic        tog_s1;
    logic        tog_s2;
    logic        tog_s3;
    logic        load_s1;
    logic        load_s2;
    logic        load_s3;
    logic        clr_s1;
    logic        clr_s2;
    logic        lvl_s1;
    logic        lvl_s2;

    word_t       frame_reg;
    count_t      frame_cnt_reg;
    logic        pending_reg;
    logic        soft_clear_reg;
    logic        soft_load_reg;
    logic        dac_update_reg;

    code_t       input_reg [4];
    code_t       dac_reg   [4];

    logic [31:0] prdata_reg;
    logic [31:0] rdata_next;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        addr_ok;

    logic        frame_evt;
    logic        load_go;
    logic        clear_now;
    code_t       preset_code;
    chan_t       word_ch;
    code_t       word_data;
    logic        setup_ph;
    logic        wr_en;

    // ----------------------------------------------------------------
    // Link-side logic
    // ----------------------------------------------------------------
    serial_shift u_shift
    (
        .serial_clk    (serial_clk),
        .presetn       (presetn),
        .sel_n         (sel_n),
        .serial_bit_in (serial_bit_in),
        .word_hold     (word_hold),
        .word_toggle   (word_toggle)
    );

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end
        else
        begin
            tog_s1 <= word_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // Strobe pins idle high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load_s1 <= 1'b1;
            load_s2 <= 1'b1;
            load_s3 <= 1'b1;
        end
        else
        begin
            load_s1 <= load_strobe_n;
            load_s2 <= load_s1;
            load_s3 <= load_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clr_s1 <= 1'b1;
            clr_s2 <= 1'b1;
            lvl_s1 <= 1'b0;
            lvl_s2 <= 1'b0;
        end
        else
        begin
            clr_s1 <= preset_strobe_n;
            clr_s2 <= clr_s1;
            lvl_s1 <= preset_level_choice;
            lvl_s2 <= lvl_s1;
        end
    end

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    // Word is stable for a full frame after the toggle, far longer
    // than the synchroniser delay, so sampling it here is safe
    assign frame_evt   = tog_s2 ^ tog_s3;
    assign load_go     = (load_s3 & ~load_s2) | soft_load_reg;  // [R6]
    // Runs on pclk only: no link clock edge is needed
    assign clear_now   = ~clr_s2 | soft_clear_reg;             // [R11]
    assign preset_code = lvl_s2 ? `CODE_MID : `CODE_ZERO;      // [R8]
    assign word_ch     = frame_reg[`WORD_CH_HI:`WORD_CH_LO];   // [R12]
    assign word_data   = frame_reg[`WORD_DATA_HI:`WORD_DATA_LO];

    // ----------------------------------------------------------------
    // Last complete serial word
    // ----------------------------------------------------------------
    // Clear leaves this copy alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_reg     <= 16'h0000;
            frame_cnt_reg <= 16'h0000;
        end
        else if (frame_evt)                                    // [R9]
        begin
            frame_reg     <= word_hold;
            frame_cnt_reg <= frame_cnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Input and DAC code registers
    // ----------------------------------------------------------------
    // Double buffered: the loaded channel takes the new code, the
    // others move their held input code across at the same moment
    for (genvar ch = 0; ch < 4; ch++)
    begin : g_chan
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                input_reg[ch] <= `CODE_ZERO;
                dac_reg[ch]   <= `CODE_ZERO;
            end
            else if (clear_now)                            // [R8] [R11]
            begin
                input_reg[ch] <= preset_code;
                dac_reg[ch]   <= preset_code;
            end
            else if (load_go)                                    // [R6]
            begin
                if (word_ch == chan_t'(ch))
                begin
                    input_reg[ch] <= word_data;
                    dac_reg[ch]   <= word_data;
                end
                else
                    dac_reg[ch]   <= input_reg[ch];
            end
        end
    end

    assign dac_code_0 = dac_reg[0];
    assign dac_code_1 = dac_reg[1];
    assign dac_code_2 = dac_reg[2];
    assign dac_code_3 = dac_reg[3];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dac_update_reg <= 1'b0;
        else
            dac_update_reg <= load_go & ~clear_now;
    end

    assign dac_update = dac_update_reg;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states; pready is registered from the setup phase
    assign setup_ph = psel & ~penable;
    assign wr_en    = psel & penable & pwrite & pready_reg & ~pslverr_reg;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        addr_ok    = 1'b1;
        if (paddr[1:0] != 2'b00)
            addr_ok = 1'b0;
        else if (paddr == `OFF_CTRL)
            rdata_next[`CTRL_SOFT_CLEAR] = soft_clear_reg;
        else if (paddr == `OFF_STATUS)
        begin
            rdata_next[`STAT_PENDING]  = pending_reg;
            rdata_next[`STAT_CLEARING] = clear_now;
            rdata_next[`STAT_LEVEL]    = lvl_s2;
            rdata_next[`STAT_CNT_HI:`STAT_CNT_LO] = frame_cnt_reg;
        end
        else if (paddr == `OFF_FRAME)
            rdata_next[15:0] = frame_reg;
        else if (paddr[7:4] == `BANK_INPUT)
            rdata_next[11:0] = input_reg[paddr[3:2]];
        else if (paddr[7:4] == `BANK_DAC)
            rdata_next[11:0] = dac_reg[paddr[3:2]];
        else
            addr_ok = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            pready_reg  <= setup_ph;
            pslverr_reg <= setup_ph & ~addr_ok;
            if (setup_ph)
                prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Soft load is a one-cycle pulse; writing 0 there does nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_clear_reg <= 1'b0;
            soft_load_reg  <= 1'b0;
        end
        else
        begin
            soft_load_reg <= 1'b0;
            if (wr_en && paddr == `OFF_CTRL)
            begin
                soft_clear_reg <= pwdata[`CTRL_SOFT_CLEAR];
                soft_load_reg  <= pwdata[`CTRL_SOFT_LOAD];
            end
        end
    end

    // ----------------------------------------------------------------
    // Status: new-word flag
    // ----------------------------------------------------------------
    // A word arriving in the clearing cycle keeps the flag set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pending_reg <= 1'b0;
        else if (frame_evt)
            pending_reg <= 1'b1;
        else if (wr_en && paddr == `OFF_STATUS && pwdata[`STAT_PENDING])
            pending_reg <= 1'b0;
    end

endmodule

// [bench/link_host.sv]
// Serial controller model driving the three-wire link
`timescale 1ns/1ps

module link_host (
    output logic serial_clk,
    output logic sel_n,
    output logic serial_bit_in
);
    // Link clock starts low with select high; only stray_clocks runs it outside frames
    initial
    begin
        serial_clk    = 1'b0;
        sel_n         = 1'b1;
        serial_bit_in = 1'b0;
    end

    // One word, MSB first, select low throughout
    task automatic send_word(input logic [15:0] w);
        sel_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            serial_bit_in = w[i]; // Valid before the rising edge
            #40 serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
        end
        #40 sel_n = 1'b1;
        serial_bit_in = ~serial_bit_in;
        // Deselect gap, so a following frame never glitches select
        #40;
    endtask

    // Clock edges with select high; data keeps changing
    task automatic stray_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            serial_bit_in = ~serial_bit_in;
            #40 serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
        end
    endtask
endmodule

// [bench/dac_front_chk.sv]
// Assertion checker for the quad DAC front end
`timescale 1ns/1ps

module dac_front_chk
    import dac_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        load_strobe_n,
    input wire logic        preset_strobe_n,
    input wire logic        preset_level_choice,
    input dac_pkg::code_t   dac_code_0,
    input dac_pkg::code_t   dac_code_3,
    input wire logic        dac_update
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_timing: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_access: assert property
        (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside first access cycle");
    chk_ready_drop: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_slverr_zero: assert property
        (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("refused access bad answer");
    chk_clear_mid: assert property
        ((!preset_strobe_n && preset_level_choice)[*5]
         |-> dac_code_0 == 12'h800 && dac_code_3 == 12'h800)
        else $error("clear midscale wrong");
    chk_clear_zero: assert property
        ((!preset_strobe_n && !preset_level_choice)[*5]
         |-> dac_code_0 == 12'h000 && dac_code_3 == 12'h000)
        else $error("clear zero wrong");
    chk_update_pulse: assert property (dac_update |=> !dac_update)
        else $error("update pulse too long");
    chk_load_update: assert property
        ($fell(load_strobe_n) && preset_strobe_n
         && $past(preset_strobe_n, 4) |-> ##[2:6] dac_update)
        else $error("load gave no update");
    chk_codes_hold: assert property
        ((load_strobe_n && preset_strobe_n && !psel)[*8]
         |-> $stable(dac_code_0) && $stable(dac_code_3))
        else $error("codes moved without load or clear");
endmodule

bind quad_dac_serial_load_clear dac_front_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_strobe_n(load_strobe_n), .preset_strobe_n(preset_strobe_n),
    .preset_level_choice(preset_level_choice),
    .dac_code_0(dac_code_0), .dac_code_3(dac_code_3),
    .dac_update(dac_update)
);

// [bench/quad_dac_serial_load_clear_tb_top.sv]
// Self-checking bench for the quad DAC front end
`timescale 1ns/1ps

module quad_dac_serial_load_clear_tb_top;
    import dac_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err, serial_clk, sel_n, serial_bit_in, dac_update;
    logic        load_strobe_n, preset_strobe_n, preset_level_choice;
    code_t       dac_code_0, dac_code_1, dac_code_2, dac_code_3;
    int          errors, checks_done;

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    quad_dac_serial_load_clear dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clk(serial_clk), .sel_n(sel_n),
        .serial_bit_in(serial_bit_in), .load_strobe_n(load_strobe_n),
        .preset_strobe_n(preset_strobe_n),
        .preset_level_choice(preset_level_choice),
        .dac_code_0(dac_code_0), .dac_code_1(dac_code_1),
        .dac_code_2(dac_code_2), .dac_code_3(dac_code_3),
        .dac_update(dac_update)
    );

    link_host u_host (
        .serial_clk(serial_clk), .sel_n(sel_n),
        .serial_bit_in(serial_bit_in)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(1'b0, 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(err, 1'b0);
        chk(rd, exp);
    endtask

    // No frame is sent while the strobe is low
    task automatic pulse_load();
        load_strobe_n <= 1'b0;
        cyc(4);
        chk(dac_update, 1'b1);
        cyc(1);
        load_strobe_n <= 1'b1;
        cyc(8);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_frame();
        u_host.send_word(16'hB123);
        cyc(10);
        rd_chk(8'h08, 32'h0000_B123);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd[23:8], 16'h0001);
    endtask

    task automatic t_deselect();
        u_host.stray_clocks(20);
        cyc(10);
        rd_chk(8'h08, 32'h0000_B123);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd[23:8], 16'h0001);
    endtask

    task automatic t_load(input logic [11:0] other);
        pulse_load();
        chk(dac_code_2, 12'h123);
        chk(dac_code_0, other);
        rd_chk(8'h18, 32'h0000_0123);
    endtask

    task automatic t_clear(input logic lvl, input logic [11:0] code);
        preset_level_choice <= lvl;
        cyc(4);
        preset_strobe_n <= 1'b0;
        cyc(6);
        chk({dac_code_0, dac_code_1}, {code, code});
        chk({dac_code_2, dac_code_3}, {code, code});
        rd_chk(8'h18, {20'h0_0000, code});
        rd_chk(8'h08, 32'h0000_B123);
        preset_strobe_n <= 1'b1;
        cyc(4);
    endtask

    task automatic t_back_to_back();
        u_host.send_word(16'h4ABC);
        u_host.send_word(16'hC7FF);
        cyc(10);
        rd_chk(8'h08, 32'h0000_C7FF);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd[23:8], 16'h0003);
        pulse_load();
        chk(dac_code_3, 12'h7FF);
    endtask

    task automatic t_soft();
        u_host.send_word(16'h0555);
        cyc(10);
        rd_chk(8'h04, 32'h0000_0401);
        apb(1'b1, 8'h04, 32'h0000_0001);
        rd_chk(8'h04, 32'h0000_0400);
        apb(1'b1, 8'h00, 32'h0000_0002);
        cyc(2);
        chk(dac_code_0, 12'h555);
        rd_chk(8'h20, 32'h0000_0555);
        apb(1'b1, 8'h00, 32'h0000_0001);
        cyc(2);
        rd_chk(8'h00, 32'h0000_0001);
        rd_chk(8'h04, 32'h0000_0402);
        chk(dac_code_0, 12'h000);
        rd_chk(8'h08, 32'h0000_0555);
        apb(1'b1, 8'h00, 32'h0000_0000);
        cyc(3);
    endtask

    task automatic t_refused();
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000});
        apb(1'b1, 8'h05, 32'h0000_0003);
        chk(err, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #500000;
        errors++;
        end_of_test();
    end

    initial
    begin
        errors = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        load_strobe_n = 1'b1;
        preset_strobe_n = 1'b1;
        preset_level_choice = 1'b0;
        cyc(12);
        presetn <= 1'b1;
        cyc(2);
        chk(dac_code_2, 12'h000);
        t_frame();
        t_deselect();
        t_load(12'h000);
        t_clear(1'b1, 12'h800);
        t_load(12'h800);
        t_clear(1'b0, 12'h000);
        t_back_to_back();
        t_soft();
        t_refused();
        end_of_test();
    end
endmodule
